// File: rmac_regs.svh
// Purpose: offsets, field positions, reset values and figures of the radio
//          filter, modulation and frequency-loop configuration bank
// Assumes: registers sit at their printed offsets on a 10-bit byte address
// Notes:   included by the register bank, its checker and the testbench
//
// Overview of operation
// - bandwidth code 0..3 picks 100/150/200/300 kHz
// - 300 kHz filter moves IF to 300 kHz
// - tx code: FSK, GFSK, OOK, carrier; 4-7 reserved
// - rx code 0 FSK, 2 OOK; others reserved
// - track mode 0: loop runs freely
// - track mode 1: loop switched off
// - track mode 2: loop holds present correction
// - track mode 3: track until detection, then lock
// - lock on sync only when tolerance zero
// - proportional gain is two to the code
// - integral gain is two to the code
// - tolerance zero disables preamble detection
`ifndef RMAC_REGS_SVH
`define RMAC_REGS_SVH

// ***************************************************************
// register map
// ***************************************************************
`define RMAC_ADDR_W        10
`define RMAC_OFS_RADIO     10'h115
`define RMAC_OFS_MODE      10'h116
`define RMAC_OFS_GAIN      10'h117
`define RMAC_OFS_STAT      10'h1f0

// ***************************************************************
// reset values
// ***************************************************************
`define RMAC_RST_RADIO     8'h00
`define RMAC_RST_MODE      8'h08
`define RMAC_RST_GAIN      8'h37

// ***************************************************************
// status fields and frequency figures
// ***************************************************************
`define RMAC_ST_RSVD       0
`define RMAC_ST_STATE_LSB  1
`define RMAC_ST_LOCKED     3
`define RMAC_ST_OOK        4
`define RMAC_KHZ_W         9
`define RMAC_BW0_KHZ       9'd100
`define RMAC_BW1_KHZ       9'd150
`define RMAC_BW2_KHZ       9'd200
`define RMAC_BW3_KHZ       9'd300
`define RMAC_IF_STD_KHZ    9'd200
`define RMAC_IF_WIDE_KHZ   9'd300

`endif

// File: rmac_pkg.sv
// Purpose: types of the radio configuration bank
// Assumes: field order of each struct is the bit order of its register
// Notes:   constants live in rmac_regs.svh
package rmac_pkg;

   typedef enum logic [1:0] {BW_100K, BW_150K, BW_200K, BW_300K} rmac_bw_t;
   typedef enum logic [2:0] {TXM_FSK, TXM_GFSK, TXM_OOK, TXM_CARRIER} rmac_tx_mod_t;
   typedef enum logic [2:0] {RXD_FSK, RXD_RSVD1, RXD_OOK} rmac_rx_demod_t;
   typedef enum logic [1:0] {TRK_FREE, TRK_OFF, TRK_HOLD, TRK_LOCK} rmac_track_t;
   typedef enum logic [1:0] {LP_OFF, LP_RUN, LP_HOLD, LP_LOCKED} rmac_loop_state_t;

   typedef struct packed {
      logic [1:0] rx_filter_bw_sel;
      logic [2:0] tx_modulation_sel;
      logic [2:0] rx_demod_sel;
   } rmac_radio_cfg_t;

   typedef struct packed {
      logic [2:0] reserved;
      logic       freq_loop_polarity;
      logic [1:0] freq_loop_scheme;
      logic [1:0] freq_track_mode;
   } rmac_mode_cfg_t;

   typedef struct packed {
      logic [3:0] freq_loop_prop_gain;
      logic [3:0] freq_loop_int_gain;
   } rmac_gain_cfg_t;

endpackage

// File: rmac_freq_loop.sv
// Purpose: proportional-integral frequency correction loop with track modes
// Assumes: error samples and detection strobes come from logic on clk
// Notes:   correction saturates instead of wrapping
`timescale 1ns/1ns
module rmac_freq_loop
   import rmac_pkg::*;
#(
   parameter int ERR_W  = 12,
   parameter int CORR_W = 28
) (
   input  wire logic                     clk,
   input  wire logic                     srst,
   input  wire rmac_track_t              mode,
   input  wire logic                     ook,
   input  wire logic [3:0]               prop_code,
   input  wire logic [3:0]               int_code,
   input  wire logic signed [ERR_W-1:0]  err,
   input  wire logic                     err_valid,
   input  wire logic                     lock_evt,
   input  wire logic                     restart,
   output logic signed [CORR_W-1:0]      corr,
   output rmac_loop_state_t              state
);

   if (CORR_W < ERR_W + 16) begin : g_chk
      $error("CORR_W must hold ERR_W shifted by fifteen plus sign");
   end

   function automatic logic signed [CORR_W-1:0] shl(input logic signed [ERR_W-1:0] e,
                                                     input logic [3:0] code);
      logic signed [CORR_W-1:0] ext;
      ext = CORR_W'(e);
      return ext <<< code;
   endfunction

   function automatic logic signed [CORR_W-1:0] sat_add(input logic signed [CORR_W-1:0] a,
                                                         input logic signed [CORR_W-1:0] b);
      logic signed [CORR_W:0] s;
      s = {a[CORR_W-1], a} + {b[CORR_W-1], b};
      if (s[CORR_W] != s[CORR_W-1])
         return s[CORR_W] ? {1'b1, {(CORR_W-1){1'b0}}} : {1'b0, {(CORR_W-1){1'b1}}};
      return s[CORR_W-1:0];
   endfunction

   rmac_loop_state_t         state_q, state_d;
   logic signed [CORR_W-1:0] integ_q, integ_d, corr_q, corr_d;
   logic                     upd;

   always_comb begin
      case (mode)
         TRK_FREE: state_d = LP_RUN;
         TRK_OFF:  state_d = LP_OFF;
         TRK_HOLD: state_d = LP_HOLD;
         default: begin
            if (state_q == LP_LOCKED && !restart)
               state_d = LP_LOCKED;
            else if (lock_evt)
               state_d = LP_LOCKED;
            else
               state_d = LP_RUN;
         end
      endcase
   end

   // in OOK the gain fields drive the threshold loop, so this loop holds unless off
   assign upd     = (state_q == LP_RUN) && err_valid && !ook;
   assign integ_d = (state_q == LP_OFF) ? '0 :
                    upd ? sat_add(integ_q, shl(err, int_code)) : integ_q;
   assign corr_d  = (state_q == LP_OFF) ? '0 :
                    upd ? sat_add(integ_d, shl(err, prop_code)) : corr_q;

   always_ff @(posedge clk) begin
      if (srst) begin
         state_q <= LP_OFF;
         integ_q <= '0;
         corr_q  <= '0;
      end else begin
         state_q <= state_d;
         integ_q <= integ_d;
         corr_q  <= corr_d;
      end
   end

   assign corr  = corr_q;
   assign state = state_q;

endmodule

// File: rmac_afc_cfg_regs.sv
// Purpose: byte configuration bank for receive filter, modulation and
//          frequency-control loop, plus the loop it steers
// Assumes: plain register port; read data valid only the cycle after RD
// Notes:   unmapped reads return zero, unmapped writes are dropped
`timescale 1ns/1ns
`include "rmac_regs.svh"
module rmac_afc_cfg_regs
   import rmac_pkg::*;
#(
   parameter int ERR_W  = 12,
   parameter int CORR_W = 28
) (
   input  wire logic                       CLK,
   input  wire logic                       SRST,
   input  wire logic [`RMAC_ADDR_W-1:0]    ADDR,
   input  wire logic [7:0]                 WDATA,
   input  wire logic                       WR,
   input  wire logic                       RD,
   output logic [7:0]                      RDATA,
   input  wire logic [3:0]                 PREAMBLE_MATCH,
   input  wire logic                       PREAMBLE_DET,
   input  wire logic                       SYNC_DET,
   input  wire logic                       RX_START,
   input  wire logic signed [ERR_W-1:0]    FREQ_ERR,
   input  wire logic                       FREQ_ERR_VALID,
   output logic [`RMAC_KHZ_W-1:0]          RX_BW_KHZ,
   output rmac_bw_t                        RX_BW,
   output logic [`RMAC_KHZ_W-1:0]          RX_IF_KHZ,
   output rmac_tx_mod_t                    TX_MOD,
   output logic                            TX_MOD_OK,
   output rmac_rx_demod_t                  RX_DEMOD,
   output logic                            RX_DEMOD_OK,
   output logic                            RX_OOK,
   output logic                            FREQ_LOOP_POLARITY,
   output logic [1:0]                      FREQ_LOOP_SCHEME,
   output logic [3:0]                      FREQ_PROP_SHIFT,
   output logic [3:0]                      FREQ_INT_SHIFT,
   output logic [3:0]                      OOK_THR_PROP_SHIFT,
   output logic [3:0]                      OOK_THR_INT_SHIFT,
   output logic                            OOK_THR_EN,
   output logic signed [CORR_W-1:0]        FREQ_CORR,
   output logic                            FREQ_LOCKED,
   output rmac_loop_state_t                FREQ_LOOP_STATE,
   output logic                            CFG_RSVD_ERR
);

   // ***************************************************************
   // functions
   // ***************************************************************

   function automatic logic [`RMAC_KHZ_W-1:0] bw_khz(input logic [1:0] code);
      logic [`RMAC_KHZ_W-1:0] k;
      k = `RMAC_BW0_KHZ;
      case (code)
         2'h0:    k = `RMAC_BW0_KHZ;
         2'h1:    k = `RMAC_BW1_KHZ;
         2'h2:    k = `RMAC_BW2_KHZ;
         default: k = `RMAC_BW3_KHZ;
      endcase
      return k;
   endfunction

   function automatic logic tx_code_ok(input logic [2:0] code);
      return code <= 3'(TXM_CARRIER);
   endfunction

   function automatic logic rx_code_ok(input logic [2:0] code);
      return (code == 3'(RXD_FSK)) || (code == 3'(RXD_OOK));
   endfunction

   // ***************************************************************
   // register port decode
   // ***************************************************************

   logic hit_radio;
   logic hit_mode;
   logic hit_gain;
   logic hit_stat;
   logic wr_radio;
   logic wr_mode;
   logic wr_gain;

   assign hit_radio = (ADDR == `RMAC_OFS_RADIO);
   assign hit_mode  = (ADDR == `RMAC_OFS_MODE);
   assign hit_gain  = (ADDR == `RMAC_OFS_GAIN);
   assign hit_stat  = (ADDR == `RMAC_OFS_STAT);
   assign wr_radio  = WR && hit_radio;
   assign wr_mode   = WR && hit_mode;
   assign wr_gain   = WR && hit_gain;

   // ***************************************************************
   // configuration registers
   // ***************************************************************

   rmac_radio_cfg_t radio_q;
   rmac_radio_cfg_t radio_d;
   rmac_mode_cfg_t  mode_q;
   rmac_mode_cfg_t  mode_d;
   rmac_gain_cfg_t  gain_q;
   rmac_gain_cfg_t  gain_d;

   // every bit is stored as written, reserved codes included, so a
   // readback shows exactly what software put there
   assign radio_d = wr_radio ? rmac_radio_cfg_t'(WDATA) : radio_q;
   assign mode_d  = wr_mode  ? rmac_mode_cfg_t'(WDATA)  : mode_q;
   assign gain_d  = wr_gain  ? rmac_gain_cfg_t'(WDATA)  : gain_q;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         radio_q <= rmac_radio_cfg_t'(`RMAC_RST_RADIO);
         mode_q  <= rmac_mode_cfg_t'(`RMAC_RST_MODE);
         gain_q  <= rmac_gain_cfg_t'(`RMAC_RST_GAIN);
      end else begin
         radio_q <= radio_d;
         mode_q  <= mode_d;
         gain_q  <= gain_d;
      end
   end

   // ***************************************************************
   // decoded configuration
   // ***************************************************************

   logic                   is_ook;
   logic                   tx_ok;
   logic                   rx_ok;
   logic                   mode_rsvd;
   logic [`RMAC_KHZ_W-1:0] bw_khz_d;
   logic [`RMAC_KHZ_W-1:0] if_khz_d;

   assign is_ook    = (radio_q.rx_demod_sel == 3'(RXD_OOK));
   assign tx_ok     = tx_code_ok(radio_q.tx_modulation_sel);
   assign rx_ok     = rx_code_ok(radio_q.rx_demod_sel);
   // the fixed fields are checked only to flag a misprogrammed word
   assign mode_rsvd = (mode_q.reserved != 3'h0) || mode_q.freq_loop_polarity ||
                      (mode_q.freq_loop_scheme != 2'h2);
   assign bw_khz_d  = bw_khz(radio_q.rx_filter_bw_sel);
   // no extra write is needed: the IF follows the widest filter at once
   assign if_khz_d  = (radio_q.rx_filter_bw_sel == 2'(BW_300K)) ?
                      `RMAC_IF_WIDE_KHZ : `RMAC_IF_STD_KHZ;

   // ***************************************************************
   // lock event selection
   // ***************************************************************

   logic pre_disabled;
   logic lock_evt;

   // zero tolerance disables preamble detection, so sync is the only cue
   assign pre_disabled = (PREAMBLE_MATCH == 4'h0);
   assign lock_evt     = pre_disabled ? SYNC_DET : PREAMBLE_DET;

   // ***************************************************************
   // frequency correction loop
   // ***************************************************************

   logic signed [CORR_W-1:0] corr;
   rmac_loop_state_t         loop_state;

   rmac_freq_loop #(
      .ERR_W  (ERR_W),
      .CORR_W (CORR_W)
   ) u_loop (
      .clk       (CLK),
      .srst      (SRST),
      .mode      (rmac_track_t'(mode_q.freq_track_mode)),
      .ook       (is_ook),
      .prop_code (gain_q.freq_loop_prop_gain),
      .int_code  (gain_q.freq_loop_int_gain),
      .err       (FREQ_ERR),
      .err_valid (FREQ_ERR_VALID),
      .lock_evt  (lock_evt),
      .restart   (RX_START),
      .corr      (corr),
      .state     (loop_state)
   );

   // ***************************************************************
   // status word
   // ***************************************************************

   logic       rsvd_err;
   logic       locked;
   logic [7:0] stat_word;

   assign rsvd_err = !tx_ok || !rx_ok || mode_rsvd;
   assign locked   = (loop_state == LP_LOCKED);

   always_comb begin
      stat_word                                 = 8'h00;
      stat_word[`RMAC_ST_RSVD]                  = rsvd_err;
      stat_word[`RMAC_ST_STATE_LSB +: 2]        = 2'(loop_state);
      stat_word[`RMAC_ST_LOCKED]                = locked;
      stat_word[`RMAC_ST_OOK]                   = is_ook;
   end

   // ***************************************************************
   // read path
   // ***************************************************************

   logic [7:0] rd_sel;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;

   always_comb begin
      if (hit_radio)
         rd_sel = radio_q;
      else if (hit_mode)
         rd_sel = mode_q;
      else if (hit_gain)
         rd_sel = gain_q;
      else if (hit_stat)
         rd_sel = stat_word;
      else
         rd_sel = 8'h00;
   end

   // data stand only the cycle after the strobe, zero otherwise
   assign rdata_d = RD ? rd_sel : 8'h00;

   always_ff @(posedge CLK) begin
      if (SRST)
         rdata_q <= 8'h00;
      else
         rdata_q <= rdata_d;
   end

   assign RDATA = rdata_q;

   // ***************************************************************
   // registered configuration outputs
   // ***************************************************************

   logic [`RMAC_KHZ_W-1:0] bw_khz_q;
   logic [`RMAC_KHZ_W-1:0] if_khz_q;
   logic                   tx_ok_q;
   logic                   rx_ok_q;
   logic                   ook_q;
   logic [3:0]             fp_q;
   logic [3:0]             fi_q;
   logic [3:0]             op_q;
   logic [3:0]             oi_q;
   logic                   rsvd_q;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         bw_khz_q <= `RMAC_BW0_KHZ;
         if_khz_q <= `RMAC_IF_STD_KHZ;
         tx_ok_q  <= 1'b0;
         rx_ok_q  <= 1'b0;
         ook_q    <= 1'b0;
         fp_q     <= 4'h0;
         fi_q     <= 4'h0;
         op_q     <= 4'h0;
         oi_q     <= 4'h0;
         rsvd_q   <= 1'b0;
      end else begin
         bw_khz_q <= bw_khz_d;
         if_khz_q <= if_khz_d;
         tx_ok_q  <= tx_ok;
         rx_ok_q  <= rx_ok;
         ook_q    <= is_ook;
         // each gain pair feeds exactly one loop; the unused one reads zero
         fp_q     <= is_ook ? 4'h0 : gain_q.freq_loop_prop_gain;
         fi_q     <= is_ook ? 4'h0 : gain_q.freq_loop_int_gain;
         op_q     <= is_ook ? gain_q.freq_loop_prop_gain : 4'h0;
         oi_q     <= is_ook ? gain_q.freq_loop_int_gain : 4'h0;
         rsvd_q   <= rsvd_err;
      end
   end

   rmac_bw_t       bw_q;
   rmac_tx_mod_t   txm_q;
   rmac_rx_demod_t rxd_q;
   logic           pol_q;
   logic [1:0]     sch_q;

   always_ff @(posedge CLK) begin
      if (SRST) begin
         bw_q  <= BW_100K;
         txm_q <= TXM_FSK;
         rxd_q <= RXD_FSK;
         pol_q <= 1'b0;
         sch_q <= 2'h0;
      end else begin
         bw_q  <= rmac_bw_t'(radio_q.rx_filter_bw_sel);
         txm_q <= rmac_tx_mod_t'(radio_q.tx_modulation_sel);
         rxd_q <= rmac_rx_demod_t'(radio_q.rx_demod_sel);
         pol_q <= mode_q.freq_loop_polarity;
         sch_q <= mode_q.freq_loop_scheme;
      end
   end

   // ***************************************************************
   // output assignment
   // ***************************************************************

   assign RX_BW_KHZ          = bw_khz_q;
   assign RX_BW              = bw_q;
   assign RX_IF_KHZ          = if_khz_q;
   assign TX_MOD             = txm_q;
   assign TX_MOD_OK          = tx_ok_q;
   assign RX_DEMOD           = rxd_q;
   assign RX_DEMOD_OK        = rx_ok_q;
   assign RX_OOK             = ook_q;
   assign OOK_THR_EN         = ook_q;
   assign FREQ_LOOP_POLARITY = pol_q;
   assign FREQ_LOOP_SCHEME   = sch_q;
   assign FREQ_PROP_SHIFT    = fp_q;
   assign FREQ_INT_SHIFT     = fi_q;
   assign OOK_THR_PROP_SHIFT = op_q;
   assign OOK_THR_INT_SHIFT  = oi_q;
   assign FREQ_CORR          = corr;
   assign FREQ_LOCKED        = locked;
   assign FREQ_LOOP_STATE    = loop_state;
   assign CFG_RSVD_ERR       = rsvd_q;

endmodule

// File: rmac_afc_cfg_regs_checker.sv
// Purpose: concurrent checks on the ports of the radio configuration bank
// Assumes: one clock domain, synchronous active-high reset
// Notes:   the lock-hold check skips cycles next to mode register writes
`timescale 1ns/1ns
`include "rmac_regs.svh"
module rmac_afc_cfg_regs_checker
   import rmac_pkg::*;
#(
   parameter int CORR_W = 28
) (
   input wire logic                    CLK,
   input wire logic                    SRST,
   input wire logic [`RMAC_ADDR_W-1:0] ADDR,
   input wire logic [7:0]              WDATA,
   input wire logic                    WR,
   input wire logic                    RD,
   input wire logic [7:0]              RDATA,
   input wire logic [3:0]              PREAMBLE_MATCH,
   input wire logic                    SYNC_DET,
   input wire logic                    PREAMBLE_DET,
   input wire logic                    RX_START,
   input wire logic [`RMAC_KHZ_W-1:0]  RX_BW_KHZ,
   input wire logic [`RMAC_KHZ_W-1:0]  RX_IF_KHZ,
   input wire logic                    RX_OOK,
   input wire logic [3:0]              FREQ_PROP_SHIFT,
   input wire logic [3:0]              OOK_THR_PROP_SHIFT,
   input wire logic signed [CORR_W-1:0] FREQ_CORR,
   input wire rmac_loop_state_t        FREQ_LOOP_STATE
);
   // ***********************
   // decodes and sequences
   // ***********************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   wire rd_map   = ADDR inside {`RMAC_OFS_RADIO, `RMAC_OFS_MODE, `RMAC_OFS_GAIN, `RMAC_OFS_STAT};
   wire radio_wr = WR && ADDR == `RMAC_OFS_RADIO;
   wire mode_wr  = WR && ADDR == `RMAC_OFS_MODE;
   wire locked   = FREQ_LOOP_STATE == LP_LOCKED;

   function automatic logic [`RMAC_KHZ_W-1:0] bw_khz(input logic [7:0] d);
      case (d[7:6])
         2'h0: return `RMAC_BW0_KHZ;
         2'h1: return `RMAC_BW1_KHZ;
         2'h2: return `RMAC_BW2_KHZ;
         default: return `RMAC_BW3_KHZ;
      endcase
   endfunction

   // decoded outputs land one edge after the write is taken
   sequence s_radio_set;
      radio_wr ##1 !radio_wr;
   endsequence
   sequence s_mode_quiet;
      !mode_wr ##1 !mode_wr;
   endsequence

   a_rd_unmapped_zero: assert property (RD && !rd_map |=> RDATA == 8'h00)
      else $error("unmapped read returned data");
   a_rdata_idle_zero: assert property (!RD |=> RDATA == 8'h00)
      else $error("read data without a read");
   a_bw_decode: assert property (s_radio_set |-> ##1 RX_BW_KHZ == bw_khz($past(WDATA, 2)))
      else $error("filter bandwidth decode wrong");
   a_if_shift: assert property (s_radio_set |-> ##1 RX_IF_KHZ ==
         (($past(WDATA, 2) >= 8'hc0) ? `RMAC_IF_WIDE_KHZ : `RMAC_IF_STD_KHZ))
      else $error("intermediate frequency wrong");
   a_ook_gain_route: assert property (RX_OOK ? FREQ_PROP_SHIFT == 4'h0 : OOK_THR_PROP_SHIFT == 4'h0)
      else $error("gain routed to wrong loop");
   a_sync_only_lock: assert property (!locked && PREAMBLE_MATCH == 4'h0 && !SYNC_DET |=> !locked)
      else $error("locked without sync word");
   a_preamble_lock: assert property (!locked && PREAMBLE_MATCH != 4'h0 && !PREAMBLE_DET |=> !locked)
      else $error("locked without preamble");
   a_lock_holds: assert property (s_mode_quiet ##0 (locked && !RX_START) |=> locked)
      else $error("lock released unasked");
   a_corr_hold: assert property ((FREQ_LOOP_STATE == LP_HOLD || locked) |=> $stable(FREQ_CORR))
      else $error("correction moved while held");
   a_off_clears: assert property (FREQ_LOOP_STATE == LP_OFF |=> FREQ_CORR == '0)
      else $error("correction not cleared when off");
endmodule

bind rmac_afc_cfg_regs rmac_afc_cfg_regs_checker #(.CORR_W(CORR_W)) u_rmac_afc_cfg_regs_checker (
   .CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .PREAMBLE_MATCH, .SYNC_DET, .PREAMBLE_DET, .RX_START,
   .RX_BW_KHZ, .RX_IF_KHZ, .RX_OOK, .FREQ_PROP_SHIFT, .OOK_THR_PROP_SHIFT, .FREQ_CORR, .FREQ_LOOP_STATE);

// File: rmac_afc_cfg_regs_tb.sv
// Purpose: self-checking bench of the radio configuration bank
// Assumes: read data stands only in the cycle after the read strobe
// Notes:   a small integer model follows the correction loop
`timescale 1ns/1ns
`include "rmac_regs.svh"
module rmac_afc_cfg_regs_tb
   import rmac_pkg::*;
;
   logic               CLK = 1'b0;
   logic               SRST = 1'b1;
   logic               WR, RD, PREAMBLE_DET, SYNC_DET, RX_START, FREQ_ERR_VALID;
   logic [9:0]         ADDR;
   logic [7:0]         WDATA, RDATA;
   logic [3:0]         PREAMBLE_MATCH, FREQ_PROP_SHIFT, FREQ_INT_SHIFT, OOK_THR_PROP_SHIFT, OOK_THR_INT_SHIFT;
   logic signed [11:0] FREQ_ERR;
   logic signed [27:0] FREQ_CORR;
   logic [8:0]         RX_BW_KHZ, RX_IF_KHZ;
   logic [1:0]         FREQ_LOOP_SCHEME;
   logic               TX_MOD_OK, RX_DEMOD_OK, RX_OOK, FREQ_LOOP_POLARITY, OOK_THR_EN, FREQ_LOCKED, CFG_RSVD_ERR;
   rmac_bw_t           RX_BW;
   rmac_tx_mod_t       TX_MOD;
   rmac_rx_demod_t     RX_DEMOD;
   rmac_loop_state_t   FREQ_LOOP_STATE;
   logic [7:0]         m [3];
   logic [31:0]        rng = 32'h000060b5;
   int                 integ, corr, fail_count, checks;

   rmac_afc_cfg_regs #(.ERR_W(12), .CORR_W(28)) u_rmac_afc_cfg_regs (
      .CLK, .SRST, .ADDR, .WDATA, .WR, .RD, .RDATA, .PREAMBLE_MATCH, .PREAMBLE_DET, .SYNC_DET, .RX_START,
      .FREQ_ERR, .FREQ_ERR_VALID, .RX_BW_KHZ, .RX_BW, .RX_IF_KHZ, .TX_MOD, .TX_MOD_OK, .RX_DEMOD,
      .RX_DEMOD_OK, .RX_OOK, .FREQ_LOOP_POLARITY, .FREQ_LOOP_SCHEME, .FREQ_PROP_SHIFT, .FREQ_INT_SHIFT,
      .OOK_THR_PROP_SHIFT, .OOK_THR_INT_SHIFT, .OOK_THR_EN, .FREQ_CORR, .FREQ_LOCKED, .FREQ_LOOP_STATE,
      .CFG_RSVD_ERR);

   always #5 CLK = ~CLK;

   // ***********************
   // helpers
   // ***********************
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] v;
      v = s ^ (s << 13);
      v = v ^ (v >> 17);
      return v ^ (v << 5);
   endfunction

   function automatic logic [8:0] bw_khz(input logic [1:0] c);
      return c == 2'h0 ? 9'h064 : c == 2'h1 ? 9'h096 : c == 2'h2 ? 9'h0c8 : 9'h12c;
   endfunction

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_dec();
      logic ook;
      ook = m[0][2:0] == 3'h2;
      check({RX_BW, RX_BW_KHZ}, {m[0][7:6], bw_khz(m[0][7:6])});
      check(RX_IF_KHZ, m[0][7:6] == 2'h3 ? 9'h12c : 9'h0c8);
      check({TX_MOD, RX_DEMOD, TX_MOD_OK}, {m[0][5:0], !m[0][5]});
      check({RX_DEMOD_OK, RX_OOK}, {ook || m[0][2:0] == 3'h0, ook});
      check({FREQ_PROP_SHIFT, FREQ_INT_SHIFT}, ook ? 8'h00 : m[2]);
      check({OOK_THR_PROP_SHIFT, OOK_THR_INT_SHIFT, OOK_THR_EN}, {ook ? m[2] : 8'h00, ook});
      check({FREQ_LOOP_POLARITY, FREQ_LOOP_SCHEME}, m[1][4:2]);
      check(CFG_RSVD_ERR, m[0][5] || !(ook || m[0][2:0] == 3'h0) || m[1][7:2] != 6'h02);
   endtask

   // write then read straight back, with no gap between the strobes
   task automatic wrrd(input logic [9:0] a, input logic [7:0] d);
      logic hit;
      hit = a inside {[10'h115:10'h117]};
      WR <= 1'b1;
      ADDR <= a;
      WDATA <= d;
      @(posedge CLK);
      WR <= 1'b0;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      if (hit) m[a - 10'h115] = d;
      @(negedge CLK);
      check(RDATA, hit ? d : 8'h00);
      chk_dec();
      if (a == 10'h116) check(FREQ_LOOP_STATE, d[1:0] == 2'h1 ? LP_OFF : d[1:0] == 2'h2 ? LP_HOLD : LP_RUN);
      @(posedge CLK);
   endtask

   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      RD <= 1'b1;
      ADDR <= a;
      @(posedge CLK);
      RD <= 1'b0;
      @(negedge CLK);
      check(RDATA, e);
      @(posedge CLK);
   endtask

   task automatic smp(input logic upd);
      rng = xs(rng);
      FREQ_ERR <= rng[11:0];
      FREQ_ERR_VALID <= 1'b1;
      @(posedge CLK);
      FREQ_ERR_VALID <= 1'b0;
      if (upd) begin
         integ = integ + ($signed(rng[11:0]) <<< m[2][3:0]);
         corr = integ + ($signed(rng[11:0]) <<< m[2][7:4]);
      end
      @(negedge CLK);
      check(FREQ_CORR, corr);
      @(posedge CLK);
   endtask

   task automatic pls(input logic [2:0] v, input rmac_loop_state_t s);
      {RX_START, SYNC_DET, PREAMBLE_DET} <= v;
      @(posedge CLK);
      {RX_START, SYNC_DET, PREAMBLE_DET} <= 3'h0;
      @(negedge CLK);
      check({FREQ_LOOP_STATE, FREQ_LOCKED}, {s, s == LP_LOCKED});
      @(posedge CLK);
   endtask

   task automatic stop_test();
      if (fail_count == 0 && checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ***********************
   // main sequence
   // ***********************
   initial begin
      {WR, RD, PREAMBLE_DET, SYNC_DET, RX_START, FREQ_ERR_VALID} = 6'h00;
      ADDR = 10'h000;
      WDATA = 8'h00;
      FREQ_ERR = 12'h000;
      PREAMBLE_MATCH = 4'h4;
      m = '{8'h00, 8'h08, 8'h37};
      repeat (3) @(posedge CLK);
      SRST <= 1'b0;
      @(posedge CLK);
      rd(10'h115, 8'h00);
      rd(10'h116, 8'h08);
      rd(10'h117, 8'h37);
      rd(10'h118, 8'h00);
      for (int i = 0; i < 8; i++) wrrd(10'h115, {i[1:0], i[2:0], i[2:0]});
      repeat (30) begin
         rng = xs(rng);
         wrrd(10'h115 + 10'(rng[9:8]), rng[7:0]);
      end
      wrrd(10'h115, 8'h00);
      wrrd(10'h117, 8'h21);
      wrrd(10'h116, 8'h09);
      integ = 0;
      corr = 0;
      wrrd(10'h116, 8'h08);
      repeat (3) smp(1'b1);
      wrrd(10'h116, 8'h0a);
      smp(1'b0);
      rng = xs(rng);
      PREAMBLE_MATCH <= 4'h1 + {1'b0, rng[2:0]};
      wrrd(10'h116, 8'h0b);
      smp(1'b1);
      pls(3'h2, LP_RUN);
      pls(3'h1, LP_LOCKED);
      smp(1'b0);
      pls(3'h5, LP_LOCKED);
      pls(3'h4, LP_RUN);
      PREAMBLE_MATCH <= 4'h0;
      pls(3'h1, LP_RUN);
      pls(3'h2, LP_LOCKED);
      rd(10'h1f0, 8'h0e);
      pls(3'h4, LP_RUN);
      wrrd(10'h115, 8'h02);
      smp(1'b0);
      rd(10'h1f0, 8'h12);
      // switching the loop off must clear a correction that is not zero
      wrrd(10'h116, 8'h09);
      @(negedge CLK);
      check(FREQ_CORR, 32'h00000000);
      stop_test();
   end

   // a hang ends the run as a failure
   initial begin
      repeat (5000) @(posedge CLK);
      fail_count++;
      stop_test();
   end
endmodule
